/* rtl/tmr_pkg.sv */
// package: register map, fields and modes of the two-channel 8-bit timer
package tmr_pkg;
  localparam logic [7:0] ADDR_CTRL_FIRST = 8'hB0;
  localparam logic [7:0] ADDR_CTRL_SECOND = 8'hB1;
  localparam logic [7:0] ADDR_COUNT = 8'hB2;
  localparam logic [7:0] ADDR_CMP_A = 8'hB3;
  localparam logic [7:0] ADDR_CMP_B = 8'hB4;
  localparam logic [7:0] ADDR_MASK = 8'h70;
  localparam logic [7:0] ADDR_FLAGS = 8'h37;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [7:0] COUNT_ONE = 8'h01;
  // field positions
  localparam int CMA_HI = 7;
  localparam int CMA_LO = 6;
  localparam int CMB_HI = 5;
  localparam int CMB_LO = 4;
  localparam int WM_HI = 1;
  localparam int WM_LO = 0;
  localparam int FORCE_A_BIT = 7;
  localparam int FORCE_B_BIT = 6;
  localparam int WM_HIGH_BIT = 3;
  localparam int CS_HI = 2;
  localparam int CS_LO = 0;
  localparam int FLAG_OVF = 0;
  localparam int FLAG_A = 1;
  localparam int FLAG_B = 2;
  localparam logic [7:0] MASK_CTRL_SECOND = 8'h0F;
  localparam logic [7:0] MASK_CTRL_FIRST = 8'hF3;
  localparam logic [7:0] MASK_FLAGS = 8'h07;
  localparam logic [9:0] PRESCALE_TERM = 10'h3FF;

  typedef enum logic [2:0] {
    WM_NORMAL = 3'h0,
    WM_PC_FF = 3'h1,
    WM_CLEAR_MATCH = 3'h2,
    WM_FAST_FF = 3'h3,
    WM_RSV4 = 3'h4,
    WM_PC_CMP = 3'h5,
    WM_RSV6 = 3'h6,
    WM_FAST_CMP = 3'h7
  } tmr_wave_mode_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tmr_bus_req_t;

  typedef struct packed {
    logic [1:0] mode;
    logic match;
    logic at_top;
    logic at_bottom;
    logic up;
    logic pwm_fast;
    logic pwm_pc;
    logic force_hit;
  } tmr_chan_ev_t;
endpackage

/* rtl/tmr_wave_chan.sv */
// one compare-output channel: waveform flip-flop and pin takeover
`timescale 1ns/100ps
module tmr_wave_chan (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire tmr_pkg::tmr_chan_ev_t ev,
  input wire logic [7:0] cmp_value,
  input wire logic [7:0] top_value,
  output logic wave_out,
  output logic pin_takeover
);
  import tmr_pkg::*;
  logic level;
  wire pwm = ev.pwm_fast | ev.pwm_pc;
  // compare value at top with upper mode bit: action moves to top
  wire cmp_is_top = pwm && ev.mode[1] && (cmp_value == top_value);
  wire eff_match = ev.match & ~cmp_is_top;
  wire np_hit = !pwm && (ev.match || ev.force_hit);
  // non-pwm: 01 toggle, 10 clear, 11 set
  wire np_next = (ev.mode == 2'h1) ? ~level : ev.mode[0];
  // fast: 10 clears on match sets at bottom; 11 inverted
  wire f_bot = ev.pwm_fast && ev.mode[1] && ev.at_bottom && !cmp_is_top;
  wire f_match = ev.pwm_fast && ev.mode[1] && eff_match;
  // phase correct: 10 clears on up match, sets on down match
  wire p_match = ev.pwm_pc && ev.mode[1] && eff_match;
  wire t_hit = cmp_is_top && ev.at_top;
  logic next_level;
  assign next_level = np_hit && ev.mode != 2'h0 ? np_next :
    f_match ? ev.mode[0] :
    f_bot ? ~ev.mode[0] :
    p_match ? (ev.up ? ev.mode[0] : ~ev.mode[0]) :
    t_hit ? ~ev.mode[0] : level;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      level <= 1'b0;
    end else begin
      level <= next_level;
    end
  end
  // fast/pc mode 01 is reserved: pin released
  assign pin_takeover = (ev.mode != 2'h0) && !(pwm && ev.mode == 2'h1);
  assign wave_out = level;

  a_force_toggle: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!pwm && ev.force_hit && ev.mode == 2'h1) |=> wave_out != $past(wave_out))
    else $error("forced toggle did not flip output");
  a_np_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!pwm && ev.match && ev.mode == 2'h2) |=> !wave_out)
    else $error("clear on match failed");
  a_fast_bottom: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (f_bot && !f_match && ev.mode == 2'h2) |=> wave_out)
    else $error("fast non-inverting not set at bottom");
endmodule

/* rtl/tmr_core.sv */
// timer core: registers, prescaler, counter, compare and flags
`timescale 1ns/100ps
// Notes on behaviour
// - nonzero output mode hands pin to waveform, except 01 in fast and phase correct pwm
// - non-pwm: none, toggle, clear, set on match
// - fast pwm: 01 reserved, 10/11 match vs bottom
// - phase correct: up match vs down match
// - compare at top: action done at top
// - mode field selects sequence and top
// - compare update and overflow points per mode
// - high mode bit in second control bit 3
// - force bit applies match action in non-pwm
// - force sets no flag, no clear
// - force bits read back zero
// - clock select: stop, /1 to /1024
// - counter readable and writable live
// - counter write blocks next compare match
// - compare registers checked against counter continuously
// - flag set on match, cleared by one
module tmr_core (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire tmr_pkg::tmr_bus_req_t bus,
  output logic [7:0] rdata,
  input wire logic vec_ack_ovf,
  input wire logic vec_ack_a,
  input wire logic vec_ack_b,
  output logic wave_out_a,
  output logic wave_out_b,
  output logic pin_take_a,
  output logic pin_take_b,
  output logic irq_ovf,
  output logic irq_a,
  output logic irq_b
);
  import tmr_pkg::*;

  logic [7:0] ctrl_first, ctrl_second_keep, count, cmp_a, cmp_b;
  logic [7:0] buf_a, buf_b, mask, flags;
  logic [9:0] prescale;
  logic dir_down, block_match;
  logic [7:0] next_count;
  logic next_dir_down;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  wire wr_first = bus.wr && hit(bus.addr, ADDR_CTRL_FIRST);
  wire wr_second = bus.wr && hit(bus.addr, ADDR_CTRL_SECOND);
  wire wr_count = bus.wr && hit(bus.addr, ADDR_COUNT);
  wire wr_cmp_a = bus.wr && hit(bus.addr, ADDR_CMP_A);
  wire wr_cmp_b = bus.wr && hit(bus.addr, ADDR_CMP_B);
  wire wr_mask = bus.wr && hit(bus.addr, ADDR_MASK);
  wire wr_flags = bus.wr && hit(bus.addr, ADDR_FLAGS);

  // high mode bit sits in the second control register
  tmr_wave_mode_t wmode;
  assign wmode = tmr_wave_mode_t'({ctrl_second_keep[WM_HIGH_BIT],
    ctrl_first[WM_HI:WM_LO]});
  wire [2:0] clock_select_field = ctrl_second_keep[CS_HI:CS_LO];

  wire m_fast = (wmode == WM_FAST_FF) || (wmode == WM_FAST_CMP);
  wire m_pc = (wmode == WM_PC_FF) || (wmode == WM_PC_CMP);
  wire m_ctc = (wmode == WM_CLEAR_MATCH);
  // reserved modes run as normal: the least surprising choice
  wire top_from_a = m_ctc || wmode == WM_PC_CMP || wmode == WM_FAST_CMP;
  wire [7:0] top_value = top_from_a ? cmp_a : COUNT_MAX;

  // prescaler free-runs; tick selects a tap
  logic tick;
  always_comb begin
    unique case (clock_select_field)
      3'h0: tick = 1'b0;
      3'h1: tick = 1'b1;
      3'h2: tick = &prescale[2:0];
      3'h3: tick = &prescale[4:0];
      3'h4: tick = &prescale[5:0];
      3'h5: tick = &prescale[6:0];
      3'h6: tick = &prescale[7:0];
      3'h7: tick = prescale == PRESCALE_TERM;
    endcase
  end

  wire at_top = count == top_value;
  wire at_bottom = count == COUNT_BOTTOM;
  // fast mode and phase correct: sync compare at top
  wire load_cmp = (m_fast && tick && at_top) ||
    (m_pc && tick && at_top) || !(m_fast || m_pc);
  wire match_a = tick && !block_match && hit(count, cmp_a);
  wire match_b = tick && !block_match && hit(count, cmp_b);

  always_comb begin
    next_count = count;
    next_dir_down = dir_down;
    if (m_pc) begin
      if (!dir_down && at_top) begin
        next_dir_down = 1'b1;
        next_count = count - COUNT_ONE;
      end else if (dir_down && at_bottom) begin
        next_dir_down = 1'b0;
        next_count = count + COUNT_ONE;
      end else begin
        next_count = dir_down ? count - COUNT_ONE : count + COUNT_ONE;
      end
    end else begin
      next_dir_down = 1'b0;
      next_count = at_top ? COUNT_BOTTOM : count + COUNT_ONE;
    end
  end

  // overflow: at max normally, bottom in pc, top in mode 7
  wire ovf_ev = tick && (m_pc ? (dir_down && at_bottom) :
    (wmode == WM_FAST_CMP) ? at_top : hit(count, COUNT_MAX));

  wire [7:0] flag_set = {5'h0, match_b, match_a, ovf_ev};
  wire [7:0] flag_clr = (wr_flags ? bus.wdata : RESET_BYTE) |
    {5'h0, vec_ack_b, vec_ack_a, vec_ack_ovf};

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_first <= RESET_BYTE;
      ctrl_second_keep <= RESET_BYTE;
      count <= RESET_BYTE;
      cmp_a <= RESET_BYTE;
      cmp_b <= RESET_BYTE;
      buf_a <= RESET_BYTE;
      buf_b <= RESET_BYTE;
      mask <= RESET_BYTE;
      flags <= RESET_BYTE;
      prescale <= '0;
      dir_down <= 1'b0;
      block_match <= 1'b0;
    end else begin
      prescale <= prescale + 10'h001;
      if (wr_first) ctrl_first <= bus.wdata & MASK_CTRL_FIRST;
      if (wr_second) ctrl_second_keep <= bus.wdata & MASK_CTRL_SECOND;
      if (wr_mask) mask <= bus.wdata & MASK_FLAGS;
      if (wr_cmp_a) buf_a <= bus.wdata;
      if (wr_cmp_b) buf_b <= bus.wdata;
      if (load_cmp) begin
        cmp_a <= wr_cmp_a ? bus.wdata : buf_a;
        cmp_b <= wr_cmp_b ? bus.wdata : buf_b;
      end
      // set wins over a clear in the same cycle
      flags <= (flags & ~flag_clr) | flag_set;
      if (wr_count) begin
        count <= bus.wdata;
        block_match <= 1'b1;
      end else if (tick) begin
        count <= next_count;
        dir_down <= next_dir_down;
        block_match <= 1'b0;
      end
    end
  end

  // force only in non-pwm; no flag, no counter clear
  wire non_pwm = !(m_fast || m_pc);
  wire force_a = wr_second && non_pwm && bus.wdata[FORCE_A_BIT];
  wire force_b = wr_second && non_pwm && bus.wdata[FORCE_B_BIT];

  tmr_chan_ev_t ev_a, ev_b;
  assign ev_a = '{mode: ctrl_first[CMA_HI:CMA_LO], match: match_a,
    at_top: tick && at_top, at_bottom: tick && at_bottom && m_fast,
    up: !dir_down, pwm_fast: m_fast, pwm_pc: m_pc, force_hit: force_a};
  assign ev_b = '{mode: ctrl_first[CMB_HI:CMB_LO], match: match_b,
    at_top: tick && at_top, at_bottom: tick && at_bottom && m_fast,
    up: !dir_down, pwm_fast: m_fast, pwm_pc: m_pc, force_hit: force_b};

  tmr_wave_chan u_chan_a (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .ev(ev_a), .cmp_value(cmp_a),
    .top_value(top_value), .wave_out(wave_out_a), .pin_takeover(pin_take_a));
  tmr_wave_chan u_chan_b (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .ev(ev_b), .cmp_value(cmp_b),
    .top_value(top_value), .wave_out(wave_out_b), .pin_takeover(pin_take_b));

  // force bits never stored, so reads give zero
  assign rdata = hit(bus.addr, ADDR_CTRL_FIRST) ? ctrl_first :
    hit(bus.addr, ADDR_CTRL_SECOND) ? ctrl_second_keep :
    hit(bus.addr, ADDR_COUNT) ? count :
    hit(bus.addr, ADDR_CMP_A) ? buf_a :
    hit(bus.addr, ADDR_CMP_B) ? buf_b :
    hit(bus.addr, ADDR_MASK) ? mask :
    hit(bus.addr, ADDR_FLAGS) ? flags : RESET_BYTE;

  assign irq_ovf = flags[FLAG_OVF] & mask[FLAG_OVF];
  assign irq_a = flags[FLAG_A] & mask[FLAG_A];
  assign irq_b = flags[FLAG_B] & mask[FLAG_B];

  a_count_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_count |=> count == $past(bus.wdata) && !match_a && !match_b)
    else $error("counter write not loaded or match not blocked");
  a_force_noflag: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (force_b && !match_b && !flags[FLAG_B]) |=> !flags[FLAG_B])
    else $error("forced strobe set a flag");
  a_flag_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
    match_b |=> flags[FLAG_B])
    else $error("match flag not set");
  a_force_read: assert property (@(posedge clk_sys) disable iff (sys_rst)
    hit(bus.addr, ADDR_CTRL_SECOND) |-> rdata[7:6] == 2'h0)
    else $error("force bits read nonzero");
  a_wrap_fast: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!m_pc && tick && at_top && !wr_count) |=> count == COUNT_BOTTOM)
    else $error("counter did not wrap at top");
  a_stop_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (clock_select_field == 3'h0 && !wr_count && !wr_second) |=> $stable(count))
    else $error("stopped counter moved");

  // turning at the peak is a two-step event: reach top, then fall
  sequence s_pc_peak;
    m_pc && tick && at_top && !dir_down && !wr_count;
  endsequence
  a_pc_turn: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_pc_peak |=> dir_down)
    else $error("phase correct did not turn at top");
  a_ovf_max: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!m_pc && wmode != WM_FAST_CMP && tick && at_top && top_value == COUNT_MAX)
    |=> flags[FLAG_OVF])
    else $error("overflow flag not set at max");
  a_cmp_immediate: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (wr_cmp_b && non_pwm) |=> cmp_b == $past(bus.wdata))
    else $error("compare not updated at once");
  a_vec_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (vec_ack_b && !match_b) |=> !flags[FLAG_B])
    else $error("vector ack did not clear flag");
  a_tick_stop: assert property (@(posedge clk_sys) disable iff (sys_rst)
    clock_select_field == 3'h0 |-> !tick)
    else $error("stopped clock select ticked");
  // the clear on match reuses the top wrap; a missed wrap would run on to COUNT_MAX and roll over
  a_top_ctc: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (m_ctc && tick && at_top && !wr_count) |=> count == COUNT_BOTTOM)
    else $error("clear on match did not restart");
  a_pin_free: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ctrl_first[CMB_HI:CMB_LO] == 2'h0 |-> !pin_take_b)
    else $error("pin taken with mode zero");
  a_fast_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (m_fast && !(tick && at_top) && !wr_cmp_b) |=> $stable(cmp_b))
    else $error("fast compare moved off top");
endmodule

/* test/timer_two_waveform_control_test.sv */
// self-checking bench for the two-channel timer core
`timescale 1ns/100ps
module timer_two_waveform_control_test;
  import tmr_pkg::*;
  logic clk_sys;
  logic sys_rst;
  tmr_bus_req_t bus;
  logic [7:0] rdata;
  logic vec_ack_ovf;
  logic vec_ack_a;
  logic vec_ack_b;
  logic wave_out_a;
  logic wave_out_b;
  logic pin_take_a;
  logic pin_take_b;
  logic irq_ovf;
  logic irq_a;
  logic irq_b;
  int fails;
  int checks;
  int cyc;
  logic [7:0] got;
  logic [7:0] prev;
  logic [1:0] pwm_wm [4] = '{2'h3, 2'h3, 2'h1, 2'h1};
  logic [1:0] pwm_com [4] = '{2'h2, 2'h3, 2'h2, 2'h3};
  logic [7:0] frc_com [4] = '{8'h30, 8'h20, 8'h10, 8'h10};
  logic frc_exp [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  int first_wait [4] = '{320, 320, 574, 574};
  int div_tab [7] = '{1, 8, 32, 64, 128, 256, 1024};

  tmr_core dut (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .bus(bus),
    .rdata(rdata),
    .vec_ack_ovf(vec_ack_ovf),
    .vec_ack_a(vec_ack_a),
    .vec_ack_b(vec_ack_b),
    .wave_out_a(wave_out_a),
    .wave_out_b(wave_out_b),
    .pin_take_a(pin_take_a),
    .pin_take_b(pin_take_b),
    .irq_ovf(irq_ovf),
    .irq_a(irq_a),
    .irq_b(irq_b)
  );

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // the slowest divider dominates; the ceiling leaves ample margin
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] seen);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1 bus = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    #1 bus.wr = 1'b0;
  endtask

  // rdata is combinational, so it is settled by the falling edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    #1 bus.rd = 1'b1;
    bus.addr = a;
    @(negedge clk_sys);
    d = rdata;
  endtask

  // start the counter at a clock choice, let it run, then stop it
  task automatic run(input logic [2:0] cs, input int n);
    wr(ADDR_CTRL_SECOND, {5'h00, cs});
    repeat (n) @(posedge clk_sys);
    wr(ADDR_CTRL_SECOND, 8'h00);
  endtask

  initial begin
    bus = '0;
    vec_ack_ovf = 1'b0;
    vec_ack_a = 1'b0;
    vec_ack_b = 1'b0;
    sys_rst = 1'b1;
    repeat (12) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    rd(ADDR_CTRL_SECOND, got);
    chk("ctrl_second reset", RESET_BYTE, got);
    rd(ADDR_COUNT, got);
    chk("count reset", RESET_BYTE, got);
    rd(8'hC0, got);
    chk("unmapped read", 8'h00, got);
    wr(ADDR_CTRL_SECOND, 8'hC8);
    rd(ADDR_CTRL_SECOND, got);
    chk("ctrl_second readback", 8'h08, got);
    wr(ADDR_CTRL_SECOND, 8'h00);
    wr(ADDR_CTRL_FIRST, 8'h10);
    chk("pin_take_b on", 8'h01, {7'h00, pin_take_b});
    chk("pin_take_a off", 8'h00, {7'h00, pin_take_a});
    wr(ADDR_CTRL_FIRST, 8'h00);
    chk("pin_take_b off", 8'h00, {7'h00, pin_take_b});
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CTRL_FIRST, frc_com[i]);
      wr(ADDR_CTRL_SECOND, 8'h40);
      repeat (2) @(posedge clk_sys);
      chk("forced wave_out_b", {7'h00, frc_exp[i]}, {7'h00, wave_out_b});
    end
    rd(ADDR_FLAGS, got);
    chk("flags after force", 8'h00, got);
    wr(ADDR_CTRL_FIRST, 8'hC0);
    chk("pin_take_a on", 8'h01, {7'h00, pin_take_a});
    wr(ADDR_CTRL_SECOND, 8'h80);
    repeat (2) @(posedge clk_sys);
    chk("forced wave_out_a", 8'h01, {7'h00, wave_out_a});
    wr(ADDR_CTRL_FIRST, 8'h00);
    wr(ADDR_COUNT, 8'h5A);
    rd(ADDR_COUNT, got);
    chk("count readback", 8'h5A, got);
    // prescaler runs free, so allow one tick under and two over
    for (int cs = 1; cs < 8; cs++) begin
      wr(ADDR_COUNT, 8'h00);
      run(cs[2:0], 8 * div_tab[cs - 1]);
      rd(ADDR_COUNT, got);
      chk("prescaled count", 8'h01, {7'h00, got >= 8'd7 && got <= 8'd10});
    end
    wr(ADDR_COUNT, 8'h05);
    repeat (20) @(posedge clk_sys);
    rd(ADDR_COUNT, got);
    chk("stopped count", 8'h05, got);
    wr(ADDR_CMP_B, 8'h20);
    wr(ADDR_COUNT, 8'h1C);
    wr(ADDR_FLAGS, 8'h07);
    run(3'h1, 10);
    rd(ADDR_FLAGS, got);
    chk("match flag b", 8'h04, got & 8'h04);
    wr(ADDR_MASK, 8'h04);
    chk("irq_b raised", 8'h01, {7'h00, irq_b});
    wr(ADDR_FLAGS, 8'h04);
    chk("irq_b cleared", 8'h00, {7'h00, irq_b});
    wr(ADDR_COUNT, 8'h20);
    run(3'h1, 3);
    rd(ADDR_FLAGS, got);
    chk("match blocked", 8'h00, got & 8'h04);
    wr(ADDR_FLAGS, 8'h07);
    wr(ADDR_COUNT, 8'hFD);
    run(3'h1, 6);
    rd(ADDR_FLAGS, got);
    chk("overflow at max", 8'h01, got & 8'h01);
    wr(ADDR_MASK, 8'h03);
    chk("irq_ovf raised", 8'h01, {7'h00, irq_ovf});
    chk("irq_a raised", 8'h01, {7'h00, irq_a});
    @(posedge clk_sys);
    #1 vec_ack_ovf = 1'b1;
    @(posedge clk_sys);
    #1 vec_ack_ovf = 1'b0;
    chk("irq_ovf vector clear", 8'h00, {7'h00, irq_ovf});
    rd(ADDR_COUNT, got);
    chk("normal wraps", 8'h01, {7'h00, got < 8'h10});
    wr(ADDR_FLAGS, 8'h07);
    wr(ADDR_CTRL_FIRST, 8'h01);
    wr(ADDR_COUNT, 8'hF8);
    run(3'h1, 12);
    rd(ADDR_FLAGS, got);
    chk("no overflow at max", 8'h00, got & 8'h01);
    rd(ADDR_COUNT, prev);
    run(3'h1, 4);
    rd(ADDR_COUNT, got);
    chk("counts down", 8'h01, {7'h00, got < prev});
    wr(ADDR_CTRL_FIRST, 8'h02);
    wr(ADDR_CMP_A, 8'h05);
    wr(ADDR_COUNT, 8'h00);
    run(3'h1, 40);
    rd(ADDR_COUNT, got);
    chk("clear on match top", 8'h01, {7'h00, got <= 8'h05});
    wr(ADDR_CMP_B, 8'h80);
    for (int p = 0; p < 4; p++) begin
      wr(ADDR_CTRL_FIRST, {2'h0, pwm_com[p], 2'h0, pwm_wm[p]});
      wr(ADDR_COUNT, 8'h00);
      run(3'h1, first_wait[p]);
      chk("pwm below compare", {7'h00, ~pwm_com[p][0]}, {7'h00, wave_out_b});
      run(3'h1, 128);
      chk("pwm above compare", {7'h00, pwm_com[p][0]}, {7'h00, wave_out_b});
    end
    conclude();
  end
endmodule
